/* rtl/tw_bit_engine.sv */
// bit engine: pin sampling, start/stop detection, byte shift, ack drive, clock stretch
module tw_bit_engine
   import tw_pkg::*;
(
   // clock and reset
   input  wire logic i_mclk,
   input  wire logic i_rst_b,
   // bus pins
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_scl_oe,
   output logic      o_sda_oe,
   // controller side
   tw_link_if.eng    lnk
);
   // ------------------------------------------------------------
   // synchronisers and edge history
   // ------------------------------------------------------------
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic       scl_p_q;
   logic       sda_p_q;
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_p_q    <= 1'b1;
         sda_p_q    <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], i_scl};
         sda_sync_q <= {sda_sync_q[0], i_sda};
         scl_p_q    <= scl_sync_q[1];
         sda_p_q    <= sda_sync_q[1];
      end
   end
   logic scl_s;
   logic sda_s;
   logic rise;
   logic fall;
   logic start_c;
   logic stop_c;
   assign scl_s   = scl_sync_q[1];
   assign sda_s   = sda_sync_q[1];
   assign rise    = scl_s & ~scl_p_q;
   assign fall    = ~scl_s & scl_p_q;
   // sda moving while scl stays high marks start or stop
   assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_c  = scl_s & scl_p_q & ~sda_p_q & sda_s;
   // ------------------------------------------------------------
   // engine state
   // ------------------------------------------------------------
   tw_eng_st_e st_q, st_d;
   logic [2:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d;
   logic       first_q, first_d;
   logic       sda_oe_q, sda_oe_d;
   logic       scl_oe_q, scl_oe_d;
   logic       start_q, start_d, stop_q, stop_d, byte_q, byte_d, ack_q, ack_d;
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      first_d = first_q;
      sda_oe_d = sda_oe_q;
      start_d = 1'b0;
      stop_d = 1'b0;
      byte_d = 1'b0;
      ack_d = 1'b0;
      if (!lnk.en) begin
         st_d = E_IDLE;
         sda_oe_d = 1'b0;
      end else if (start_c) begin
         st_d = E_BITS;
         cnt_d = 3'h0;
         first_d = 1'b1;
         sda_oe_d = 1'b0;
         start_d = 1'b1;
      end else if (stop_c) begin
         st_d = E_IDLE;
         sda_oe_d = 1'b0;
         stop_d = 1'b1;
      end else begin
         case (st_q)
            E_BITS: begin
               if (rise) begin
                  sh_d = {sh_q[6:0], sda_s};
                  cnt_d = cnt_q + 3'h1;
                  if (cnt_q == LAST_BIT) begin
                     byte_d = 1'b1;
                     st_d = E_WAIT8;
                  end
               end
            end
            E_WAIT8: begin
               if (fall) begin
                  // a low on sda is an ack, released sda is a not-ack
                  st_d = lnk.drop ? E_SKIP : E_ACK;
                  sda_oe_d = lnk.ack_drive & ~lnk.drop;
                  first_d = 1'b0;
               end
            end
            E_ACK: begin
               if (rise) begin
                  st_d = E_ACKEND;
               end
            end
            E_ACKEND: begin
               if (fall) begin
                  sda_oe_d = 1'b0;
                  ack_d = 1'b1;
                  st_d = E_HOLD;
               end
            end
            E_HOLD: begin
               // the flag lands one cycle after the ack pulse, so wait for it
               if (!lnk.hold && !ack_q) begin
                  st_d = E_BITS;
                  cnt_d = 3'h0;
               end
            end
            E_IDLE, E_SKIP: begin
               sda_oe_d = 1'b0;
            end
            default: begin
               st_d = E_IDLE;
            end
         endcase
      end
      scl_oe_d = (st_d == E_HOLD);
   end
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         st_q <= E_IDLE;
         cnt_q <= 3'h0;
         sh_q <= 8'h00;
         first_q <= 1'b0;
         sda_oe_q <= 1'b0;
         scl_oe_q <= 1'b0;
         start_q <= 1'b0;
         stop_q <= 1'b0;
         byte_q <= 1'b0;
         ack_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         first_q <= first_d;
         sda_oe_q <= sda_oe_d;
         scl_oe_q <= scl_oe_d;
         start_q <= start_d;
         stop_q <= stop_d;
         byte_q <= byte_d;
         ack_q <= ack_d;
      end
   end
   assign o_scl_oe    = scl_oe_q;
   assign o_sda_oe    = sda_oe_q;
   assign lnk.start_p = start_q;
   assign lnk.stop_p  = stop_q;
   assign lnk.byte_p  = byte_q;
   assign lnk.ack_p   = ack_q;
   assign lnk.first   = first_q;
   assign lnk.rx_byte = sh_q;
endmodule

/* rtl/tw_link_if.sv */
// carrier between the target controller and its bit engine
interface tw_link_if;
   logic       en;
   logic       hold;
   logic       ack_drive;
   logic       drop;
   logic       start_p;
   logic       stop_p;
   logic       byte_p;
   logic       ack_p;
   logic       first;
   logic [7:0] rx_byte;
   modport eng (input en, hold, ack_drive, drop, output start_p, stop_p, byte_p, ack_p, first, rx_byte);
   modport ctl (output en, hold, ack_drive, drop, input start_p, stop_p, byte_p, ack_p, first, rx_byte);
endinterface

/* rtl/tw_pkg.sv */
// constants and types shared by the two-wire target receiver
package tw_pkg;
   // ------------------------------------------------------------
   // register offsets on the plain register port
   // ------------------------------------------------------------
   localparam logic [1:0] OFS_OWN_ADDR = 2'h0;
   localparam logic [1:0] OFS_CONTROL  = 2'h1;
   localparam logic [1:0] OFS_STATUS   = 2'h2;
   localparam logic [1:0] OFS_DATA     = 2'h3;
   // ------------------------------------------------------------
   // control register fields, plus the broadcast enable bit of the own address register
   // ------------------------------------------------------------
   localparam int BIT_EVENT_FLAG  = 7;
   localparam int BIT_ACK_ENABLE  = 6;
   localparam int BIT_START_REQ   = 5;
   localparam int BIT_STOP_REQ    = 4;
   localparam int BIT_WRITE_COLL  = 3;
   localparam int BIT_IFACE_EN    = 2;
   localparam int BIT_IRQ_ENABLE  = 0;
   localparam int BIT_BCAST_EN    = 0;
   // ------------------------------------------------------------
   // values after reset
   // ------------------------------------------------------------
   localparam logic [7:0] RST_OWN_ADDR = 8'h00;
   localparam logic [7:0] RST_DATA     = 8'hff;
   localparam logic [1:0] RST_PRESCALE = 2'h0;
   // ------------------------------------------------------------
   // status codes with prescaler bits zero, then broadcast address and last bit index
   // ------------------------------------------------------------
   localparam logic [7:0] ST_IDLE      = 8'hf8;
   localparam logic [7:0] ST_OWN_W     = 8'h60;
   localparam logic [7:0] ST_ARB_OWN_W = 8'h68;
   localparam logic [7:0] ST_BCAST     = 8'h70;
   localparam logic [7:0] ST_ARB_BCAST = 8'h78;
   localparam logic [7:0] ST_OWN_ACK   = 8'h80;
   localparam logic [7:0] ST_OWN_NACK  = 8'h88;
   localparam logic [7:0] ST_BC_ACK    = 8'h90;
   localparam logic [7:0] ST_BC_NACK   = 8'h98;
   localparam logic [7:0] ST_STOP_RX   = 8'ha0;
   localparam logic [6:0] BCAST_ADDR   = 7'h00;
   localparam logic [2:0] LAST_BIT     = 3'h7;
   // ------------------------------------------------------------
   // state types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {E_IDLE, E_BITS, E_WAIT8, E_ACK, E_ACKEND, E_HOLD, E_SKIP} tw_eng_st_e;
   typedef enum logic [1:0] {M_UNADDR, M_OWN, M_BCAST, M_TX} tw_mode_e;
endpackage

/* rtl/tw_target_rx.sv */
// two-wire target receiver: registers, address match, status codes
//
// Summary of operation
// - respond as target only to the upper seven bits of own address register.
// - own address lsb one also accepts broadcast address zero, else ignored.
// - matched address with direction 0 enters receive mode, own address with direction 1 transmit mode.
// - own address plus write bit sets the event flag with a valid code.
// - addressed after lost arbitration reports 0x68 own or 0x78 broadcast.
// - ack enable cleared means next data byte gets a not-acknowledge, sda high.
// - ack enable zero ignores own address; recognition resumes when set again.
// - in non-idle sleep with ack enable, address match still works on bus clock.
// - sleep match wakes the device and stretches scl until flag cleared.
// - data register need not hold the byte seen while waking up.
// - own address with write bit received and acked reports 0x60.
// - broadcast address acked with broadcast enable set reports 0x70.
// - acked data byte under own address reports 0x80, byte readable.
// - not-acked data byte under own address reports 0x88.
// - flag cleared in 0x60-0x80 receives next byte, ack per ack enable.
// - in 0x88 with ack enable zero become unaddressed, recognise nothing.
// - in 0x88 with ack enable one unaddressed but still recognising; start kept.
// - broadcast-addressed data byte reports 0x90 acked or 0x98 not-acked.
// - stop or repeated start while addressed reports 0xa0, then unaddressed.
module tw_target_rx
   import tw_pkg::*;
(
   // clock and reset
   input  wire logic       i_mclk,
   input  wire logic       i_rst_b,
   // register port
   input  wire logic [1:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   // bus pins, open drain
   input  wire logic       i_scl,
   output logic            o_scl,
   output logic            o_scl_oe,
   input  wire logic       i_sda,
   output logic            o_sda,
   output logic            o_sda_oe,
   // system side
   input  wire logic       i_sleep,
   input  wire logic       i_arb_lost,
   output logic            o_wake,
   output logic            o_start_pending
);
   // ------------------------------------------------------------
   // bit engine
   // ------------------------------------------------------------
   tw_link_if lnk ();
   tw_bit_engine u_eng (
      .i_mclk   (i_mclk),
      .i_rst_b  (i_rst_b),
      .i_scl    (i_scl),
      .i_sda    (i_sda),
      .o_scl_oe (o_scl_oe),
      .o_sda_oe (o_sda_oe),
      .lnk      (lnk.eng)
   );
   // ------------------------------------------------------------
   // register and mode state
   // ------------------------------------------------------------
   logic [7:0] own_q, own_d;
   logic       flag_q, flag_d;
   logic       acken_q, acken_d;
   logic       sta_q, sta_d;
   logic       sto_q, sto_d;
   logic       wc_q, wc_d;
   logic       en_q, en_d;
   logic       ie_q, ie_d;
   logic [1:0] pre_q, pre_d;
   logic [7:0] code_q, code_d;
   logic [7:0] pend_q, pend_d;
   logic [7:0] data_q, data_d;
   logic [7:0] rdata_q, rdata_d;
   logic       arb_q, arb_d;
   logic       ackdrv_q, ackdrv_d;
   logic       drop_q, drop_d;
   logic       wake_q, wake_d;
   tw_mode_e   mode_q, mode_d;
   // ------------------------------------------------------------
   // address decode of the first byte
   // ------------------------------------------------------------
   logic own_hit;
   logic bc_hit;
   logic dir_rd;
   logic recog;
   assign own_hit = (lnk.rx_byte[7:1] == own_q[7:1]);
   assign bc_hit  = (lnk.rx_byte[7:1] == BCAST_ADDR) && own_q[BIT_BCAST_EN];
   assign dir_rd  = lnk.rx_byte[0];
   // recognition follows ack enable alone, which also covers leaving 0x88/0x98
   assign recog   = acken_q;
   always_comb begin
      own_d = own_q;
      flag_d = flag_q;
      acken_d = acken_q;
      sta_d = sta_q;
      sto_d = sto_q;
      wc_d = wc_q;
      en_d = en_q;
      ie_d = ie_q;
      pre_d = pre_q;
      code_d = code_q;
      pend_d = pend_q;
      data_d = data_q;
      rdata_d = 8'h00;
      arb_d = arb_q | i_arb_lost;
      ackdrv_d = ackdrv_q;
      drop_d = drop_q;
      wake_d = 1'b0;
      mode_d = mode_q;
      // ---------------- software writes ----------------
      if (i_wr) begin
         case (i_addr)
            OFS_OWN_ADDR: begin
               own_d = i_wdata;
            end
            OFS_CONTROL: begin
               acken_d = i_wdata[BIT_ACK_ENABLE];
               sta_d = i_wdata[BIT_START_REQ];
               sto_d = i_wdata[BIT_STOP_REQ];
               en_d = i_wdata[BIT_IFACE_EN];
               ie_d = i_wdata[BIT_IRQ_ENABLE];
               if (i_wdata[BIT_EVENT_FLAG]) begin
                  flag_d = 1'b0;
               end
            end
            OFS_STATUS: begin
               pre_d = i_wdata[1:0];
            end
            OFS_DATA: begin
               data_d = i_wdata;
               wc_d = ~flag_q;
            end
            default: begin
               own_d = own_q;
            end
         endcase
      end
      // ---------------- software reads ----------------
      if (i_rd) begin
         case (i_addr)
            OFS_OWN_ADDR: rdata_d = own_q;
            OFS_CONTROL:  rdata_d = {flag_q, acken_q, sta_q, sto_q, wc_q, en_q, 1'b0, ie_q};
            OFS_STATUS:   rdata_d = {code_q[7:3], 1'b0, pre_q};
            OFS_DATA:     rdata_d = data_q;
            default:      rdata_d = 8'h00;
         endcase
      end
      // ---------------- bus events, after writes so a set wins ----------------
      if (lnk.start_p || lnk.stop_p) begin
         if (mode_q == M_OWN || mode_q == M_BCAST) begin
            code_d = ST_STOP_RX;
            flag_d = 1'b1;
         end
         mode_d = M_UNADDR;
      end
      if (lnk.byte_p) begin
         drop_d = 1'b1;
         ackdrv_d = 1'b0;
         if (lnk.first) begin
            if (recog && (own_hit || bc_hit) && !dir_rd) begin
               drop_d = 1'b0;
               ackdrv_d = 1'b1;
               wake_d = i_sleep;
               arb_d = 1'b0;
               if (own_hit) begin
                  mode_d = M_OWN;
                  pend_d = arb_q ? ST_ARB_OWN_W : ST_OWN_W;
               end else begin
                  mode_d = M_BCAST;
                  pend_d = arb_q ? ST_ARB_BCAST : ST_BCAST;
               end
            end else if (recog && own_hit && dir_rd) begin
               // transmit side is not built here: the read address is left unanswered
               mode_d = M_TX;
            end
         end else if (mode_q == M_OWN || mode_q == M_BCAST) begin
            drop_d = 1'b0;
            ackdrv_d = acken_q;
            if (mode_q == M_OWN) begin
               pend_d = acken_q ? ST_OWN_ACK : ST_OWN_NACK;
            end else begin
               pend_d = acken_q ? ST_BC_ACK : ST_BC_NACK;
            end
            // while the core clock is stopped the byte is not captured
            if (!i_sleep) begin
               data_d = lnk.rx_byte;
            end
         end
      end
      if (lnk.ack_p) begin
         flag_d = 1'b1;
         code_d = pend_q;
         if (pend_q == ST_OWN_NACK || pend_q == ST_BC_NACK) begin
            mode_d = M_UNADDR;
         end
      end
      if (!en_q) begin
         mode_d = M_UNADDR;
      end
   end
   // ------------------------------------------------------------
   // state registers
   // ------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         own_q <= RST_OWN_ADDR;
         flag_q <= 1'b0;
         acken_q <= 1'b0;
         sta_q <= 1'b0;
         sto_q <= 1'b0;
         wc_q <= 1'b0;
         en_q <= 1'b0;
         ie_q <= 1'b0;
         pre_q <= RST_PRESCALE;
         code_q <= ST_IDLE;
         pend_q <= ST_IDLE;
         data_q <= RST_DATA;
         rdata_q <= 8'h00;
         arb_q <= 1'b0;
         ackdrv_q <= 1'b0;
         drop_q <= 1'b1;
         wake_q <= 1'b0;
         mode_q <= M_UNADDR;
      end else begin
         own_q <= own_d;
         flag_q <= flag_d;
         acken_q <= acken_d;
         sta_q <= sta_d;
         sto_q <= sto_d;
         wc_q <= wc_d;
         en_q <= en_d;
         ie_q <= ie_d;
         pre_q <= pre_d;
         code_q <= code_d;
         pend_q <= pend_d;
         data_q <= data_d;
         rdata_q <= rdata_d;
         arb_q <= arb_d;
         ackdrv_q <= ackdrv_d;
         drop_q <= drop_d;
         wake_q <= wake_d;
         mode_q <= mode_d;
      end
   end
   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign lnk.en          = en_q;
   assign lnk.hold        = flag_q;
   assign lnk.ack_drive   = ackdrv_q;
   assign lnk.drop        = drop_q;
   assign o_rdata         = rdata_q;
   assign o_scl           = 1'b0;
   assign o_sda           = 1'b0;
   assign o_wake          = wake_q;
   // the controller role is outside this block; it picks the kept request up
   assign o_start_pending = sta_q & ~flag_q;
endmodule

/* tb/tw_bus_model.sv */
// bus controller model that writes bytes to the target
module tw_bus_model (
   input  wire logic i_clk,
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_scl_low,
   output logic      o_sda_low,
   output logic      o_tmo
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_scl_low = 1'b0;
      o_sda_low = 1'b0;
      o_tmo = 1'b0;
   end
   // moves land 1 ns after the edge, clear of the target's own updates
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // release scl; a bounded wait while the target stretches it
   task automatic rise();
      int k;
      k = 0;
      o_scl_low <= 1'b0;
      cyc(1);
      while (!i_scl && k < 5000) begin
         cyc(1);
         k++;
      end
      if (k >= 5000) o_tmo <= 1'b1;
   endtask
   // 180 ns bit when not stretched: 5 cycles low, 1 in the release wait, 3 high once scl is really high
   task automatic bit_io(input logic b, output logic s);
      cyc(2);
      o_sda_low <= !b;
      cyc(3);
      rise();
      cyc(2);
      s = i_sda;
      cyc(1);
      o_scl_low <= 1'b1;
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, ack);
   endtask
   // also a repeated start: release sda first, then wait for the target to let go of scl
   task automatic start();
      cyc(1);
      o_sda_low <= 1'b0;
      cyc(4);
      rise();
      cyc(2);
      o_sda_low <= 1'b1;
      cyc(3);
      o_scl_low <= 1'b1;
   endtask
   // scl stays high afterwards: the link clock stands still between frames
   task automatic stop();
      cyc(2);
      o_sda_low <= 1'b1;
      cyc(3);
      rise();
      cyc(3);
      o_sda_low <= 1'b0;
      cyc(4);
   endtask
endmodule

/* tb/tw_target_rx_chk.sv */
// port checker for the two-wire target receiver
module tw_target_rx_chk
   import tw_pkg::*;
(
   input wire logic       i_mclk,
   input wire logic       i_rst_b,
   input wire logic [1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic       i_scl,
   input wire logic       o_scl,
   input wire logic       o_scl_oe,
   input wire logic       o_sda,
   input wire logic       o_sda_oe,
   input wire logic       i_sleep,
   input wire logic       o_wake
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_b);
   // ------------------------------------------------------------
   // cycles since software last cleared the event flag
   // ------------------------------------------------------------
   logic [3:0] clr_age_q;
   logic [3:0] clr_age_d;
   always_comb begin
      clr_age_d = (clr_age_q == 4'hf) ? clr_age_q : clr_age_q + 4'h1;
      if (i_wr && i_addr == OFS_CONTROL && i_wdata[BIT_EVENT_FLAG]) clr_age_d = 4'h0;
   end
   always_ff @(posedge i_mclk) begin
      clr_age_q <= i_rst_b ? clr_age_d : 4'hf;
   end
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not zero outside the read slot");
   a_pins_open_drain: assert property (o_scl == 1'b0 && o_sda == 1'b0)
      else $error("pin data not low");
   a_wake_pulse: assert property (o_wake |=> !o_wake)
      else $error("wake longer than one cycle");
   a_wake_in_sleep: assert property (o_wake |-> $past(i_sleep))
      else $error("wake outside sleep");
   // the hold starts at the end of the ack bit, about a bit time after the wake pulse
   a_wake_stretch: assert property (o_wake |-> ##[1:30] o_scl_oe)
      else $error("wake without clock hold");
   a_stretch_min: assert property ($rose(o_scl_oe) |-> o_scl_oe [*4])
      else $error("clock hold dropped early");
   a_stretch_release: assert property ($fell(o_scl_oe) |-> clr_age_q <= 4'h3)
      else $error("clock hold released without flag clear");
   a_sda_scl_low: assert property ($rose(o_sda_oe) || $fell(o_sda_oe) |-> !i_scl)
      else $error("data line moved while clock high");
   a_ack_stretch: assert property ($rose(o_sda_oe) |-> ##[2:20] o_scl_oe)
      else $error("acked byte not followed by clock hold");
   c_wake: cover property (o_wake);
   c_ack: cover property ($rose(o_sda_oe));
   c_release: cover property ($fell(o_scl_oe));
endmodule

/* tb/tw_target_rx_tb.sv */
// self-checking bench for the two-wire target receiver
module tw_target_rx_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tw_pkg::*;
   logic i_mclk, i_rst_b, i_wr, i_rd, i_sleep, i_arb_lost, m_scl_low, m_sda_low, m_tmo;
   logic o_scl, o_scl_oe, o_sda, o_sda_oe, o_wake, o_start_pending, scl_w, sda_w;
   logic ack, got, e, alive, wake_seen;
   logic [1:0] i_addr;
   logic [7:0] i_wdata, o_rdata, rv, nx;
   logic [6:0] a;
   int n_fail, n_checks;
   // wired-and bus with pull-ups
   assign scl_w = !(m_scl_low || o_scl_oe);
   assign sda_w = !(m_sda_low || o_sda_oe);
   tw_target_rx tw_target_rx_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(scl_w), .o_scl(o_scl), .o_scl_oe(o_scl_oe),
      .i_sda(sda_w), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_sleep(i_sleep), .i_arb_lost(i_arb_lost),
      .o_wake(o_wake), .o_start_pending(o_start_pending));
   tw_bus_model tw_bus_model_inst (.i_clk(i_mclk), .i_scl(scl_w), .i_sda(sda_w), .o_scl_low(m_scl_low),
      .o_sda_low(m_sda_low), .o_tmo(m_tmo));
   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = !i_mclk;
   end
   always @(posedge i_mclk) if (o_wake === 1'b1) wake_seen <= 1'b1;
   initial begin
      repeat (60000) @(posedge i_mclk);
      chk("run_limit", 8'h01, 8'h00);
      complete_run();
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic wr(input logic [1:0] ad, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= ad;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task automatic rchk(input string what, input logic [1:0] ad, input logic [7:0] mask, input logic [7:0] exp);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= ad;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 rv = o_rdata;
      chk(what, rv & mask, exp);
   endtask
   // software side: poll the flag, check the code, then clear it with ctl; code 00 only checks that the flag stays clear
   task automatic expect_ev(input logic [7:0] st, input logic [7:0] b, input logic [7:0] ctl);
      got = 1'b0;
      if (st == 8'h00) begin
         repeat (12) @(posedge i_mclk);
         rchk("event_flag", OFS_CONTROL, 8'h80, 8'h00);
      end else begin
         for (int k = 0; k < 80 && !got; k++) begin
            rchk("poll", OFS_CONTROL, 8'h00, 8'h00);
            got = rv[BIT_EVENT_FLAG];
         end
         chk("event_flag", {7'h0, got}, 8'h01);
         if (got !== 1'b1) complete_run();
         rchk("status", OFS_STATUS, 8'hf8, st);
         if (st != ST_STOP_RX) chk("scl_hold", {7'h0, o_scl_oe}, 8'h01);
         if (st == ST_OWN_ACK || st == ST_BC_ACK) rchk("data", OFS_DATA, 8'hff, b);
         wr(OFS_CONTROL, ctl | 8'h80);
      end
   endtask
   task automatic step(input logic [7:0] b, input logic nack, input logic [7:0] st, input logic [7:0] ctl);
      tw_bus_model_inst.send(b, ack);
      chk("scl_wait", {7'h0, m_tmo}, 8'h00);
      if (m_tmo !== 1'b0) complete_run();
      chk("ack_bit", {7'h0, ack}, {7'h0, nack});
      expect_ev(st, b, ctl);
   endtask
   task automatic fin(input logic [7:0] st);
      tw_bus_model_inst.stop();
      expect_ev(st, 8'h00, 8'h44);
   endtask
   initial begin
      {i_rst_b, i_wr, i_rd, i_sleep, i_arb_lost, wake_seen} = 6'h00;
      i_addr = 2'h0;
      i_wdata = 8'h00;
      n_fail = 0;
      n_checks = 0;
      void'($urandom(91073));
      repeat (6) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      rchk("own_addr", OFS_OWN_ADDR, 8'hff, RST_OWN_ADDR);
      rchk("control", OFS_CONTROL, 8'hff, 8'h00);
      rchk("status", OFS_STATUS, 8'hff, ST_IDLE);
      rchk("data", OFS_DATA, 8'hff, RST_DATA);
      wr(OFS_STATUS, 8'hff);
      rchk("prescale", OFS_STATUS, 8'hff, 8'hfb);
      a = 7'($urandom_range(127, 1));
      wr(OFS_OWN_ADDR, {a, 1'b0});
      rchk("own_addr", OFS_OWN_ADDR, 8'hff, {a, 1'b0});
      wr(OFS_CONTROL, 8'h24);
      #1 chk("start_pending", {7'h0, o_start_pending}, 8'h01);
      wr(OFS_CONTROL, 8'h44);
      $display("test registers done");
      tw_bus_model_inst.start();
      step({a, 1'b0}, 1'b0, ST_OWN_W, 8'h44);
      step(8'($urandom), 1'b0, ST_OWN_ACK, 8'h04);
      step(8'($urandom), 1'b1, ST_OWN_NACK, 8'h04);
      step(8'($urandom), 1'b1, 8'h00, 8'h04);
      fin(8'h00);
      tw_bus_model_inst.start();
      step({a, 1'b0}, 1'b1, 8'h00, 8'h00);
      fin(8'h00);
      wr(OFS_CONTROL, 8'h44);
      tw_bus_model_inst.start();
      step({a, 1'b0}, 1'b0, ST_OWN_W, 8'h44);
      fin(ST_STOP_RX);
      $display("test own receive done");
      for (int i = 0; i < 3; i++) begin
         tw_bus_model_inst.start();
         step(i == 0 ? {a ^ 7'h01, 1'b0} : i == 1 ? {a, 1'b1} : 8'h00, 1'b1, 8'h00, 8'h00);
         fin(8'h00);
      end
      $display("test ignored addresses done");
      wr(OFS_OWN_ADDR, {a, 1'b1});
      tw_bus_model_inst.start();
      step(8'h00, 1'b0, ST_BCAST, 8'h44);
      step(8'($urandom), 1'b0, ST_BC_ACK, 8'h04);
      step(8'($urandom), 1'b1, ST_BC_NACK, 8'h44);
      tw_bus_model_inst.start();
      step({a, 1'b0}, 1'b0, ST_OWN_W, 8'h44);
      fin(ST_STOP_RX);
      for (int i = 0; i < 2; i++) begin
         @(posedge i_mclk);
         i_arb_lost <= 1'b1;
         @(posedge i_mclk);
         i_arb_lost <= 1'b0;
         tw_bus_model_inst.start();
         step(i ? 8'h00 : {a, 1'b0}, 1'b0, i ? ST_ARB_BCAST : ST_ARB_OWN_W, 8'h44);
         fin(ST_STOP_RX);
      end
      $display("test broadcast and arbitration done");
      i_sleep <= 1'b1;
      tw_bus_model_inst.start();
      step({a, 1'b0}, 1'b0, ST_OWN_W, 8'h44);
      chk("wake", {7'h0, wake_seen}, 8'h01);
      i_sleep <= 1'b0;
      step(8'($urandom), 1'b0, ST_OWN_ACK, 8'h44);
      fin(ST_STOP_RX);
      $display("test sleep wake done");
      for (int f = 0; f < 4; f++) begin
         a = 7'($urandom_range(127, 1));
         wr(OFS_OWN_ADDR, {a, 1'b0});
         wr(OFS_CONTROL, 8'h44);
         tw_bus_model_inst.start();
         step({a, 1'b0}, 1'b0, ST_OWN_W, 8'h44);
         e = 1'b1;
         alive = 1'b1;
         for (int j = 0; j < 3 && alive; j++) begin
            nx = $urandom_range(1, 0) ? 8'h44 : 8'h04;
            step(8'($urandom), !e, e ? ST_OWN_ACK : ST_OWN_NACK, nx);
            alive = e;
            e = nx[BIT_ACK_ENABLE];
         end
         fin(alive ? ST_STOP_RX : 8'h00);
      end
      $display("test random frames done");
      complete_run();
   end
endmodule
bind tw_target_rx tw_target_rx_chk tw_target_rx_chk_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(i_scl), .o_scl(o_scl),
   .o_scl_oe(o_scl_oe), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_sleep(i_sleep), .o_wake(o_wake));
